// >>> core/pbs_sram.sv
`timescale 1ns/10ps
// Overview of operation
// - Advance low steps burst counter each edge
// - Processor strobe ignored while select one high
// - Processor strobe start always reads
// - Writes after processor start or at controller start
// - Partner raises output enable before writing
// - Output enable masked during writes, asynchronous
// - Read drives pins only if enabled and selected
// - First cycle out of deselect stays floating
// - Read or write decided from write inputs and strobe type
// - Global write low writes all four bytes
// - Sleep request floats pins, ignores other inputs
// - Sleep entry and exit take two cycles
// - Array kept in sleep; pending accesses dropped
// - Partner deselects before requesting sleep
// - Partner keeps selects, strobes idle two cycles
module pbs_sram #(
    parameter int ADDR_W = pbs_pkg::ADDR_W_DEF
) (
    input wire logic sys_clk,
    input wire logic nrst,
    output logic sleeping,
    output logic selected,
    output logic write_busy,
    pbs_if.sram bus
);

    if (ADDR_W < 2 || ADDR_W > 24) begin : g_chk
        $error("pbs_sram: ADDR_W out of range");
    end

    logic [pbs_pkg::WORD_W-1:0] mem [0:(2**ADDR_W)-1];

    pbs_pkg::pbs_sram_state_t state;
    pbs_pkg::pbs_sram_state_t next_state;

    logic sleep_meta;
    logic sleep_sync;

    logic sel;
    logic processor_addr_strobe_n_act;
    logic controller_addr_strobe_n_act;
    logic start;
    logic desel;
    logic cyc_live;
    logic step;
    logic wr_cyc;
    logic [3:0] next_mask;

    logic linear;
    logic [ADDR_W-1:0] base_addr;
    logic [ADDR_W-1:0] use_addr;
    logic [ADDR_W-1:0] rd_addr;
    logic [1:0] beat;
    logic [1:0] next_beat;
    logic [1:0] use_lo;

    logic rd_stage1;
    logic rd_stage2;
    logic wr_busy;
    logic [pbs_pkg::WORD_W-1:0] dout;

    ////////////////////////////////////////////////////////////////////////////////
    // Sleep request synchroniser; two stages give the two-cycle entry and exit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
        end else begin
            sleep_meta <= bus.sleep_request;
            sleep_sync <= sleep_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-edge cycle decode
    always_comb begin
        sel = !bus.chip_select_one_n && bus.chip_select_two && !bus.chip_select_three_n;
        processor_addr_strobe_n_act = !bus.processor_addr_strobe_n && !bus.chip_select_one_n;
        controller_addr_strobe_n_act = !bus.controller_addr_strobe_n;
        start = (processor_addr_strobe_n_act || controller_addr_strobe_n_act) && sel;
        desel = (processor_addr_strobe_n_act || controller_addr_strobe_n_act) && !sel;
        cyc_live = start || (state == pbs_pkg::SR_ACTIVE && !desel);
        step = !start && !desel && !bus.burst_advance_n;
        if (start) begin
            next_beat = pbs_pkg::BEAT_FIRST;
        end else if (step) begin
            next_beat = 2'(beat + pbs_pkg::BEAT_STEP);
        end else begin
            next_beat = beat;
        end
        use_lo = pbs_pkg::burst_lo(base_addr[1:0], next_beat, linear);
        use_addr = start ? bus.addr : {base_addr[ADDR_W-1:2], use_lo};
        if (processor_addr_strobe_n_act) begin
            next_mask = pbs_pkg::MASK_NONE;
        end else begin
            next_mask = pbs_pkg::lane_mask(bus.global_write_n, bus.byte_write_enable_n,
                                           bus.byte_select_n);
        end
        // A controller start writes on its own edge; a processor start only later
        wr_cyc = cyc_live && (next_mask != pbs_pkg::MASK_NONE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Selection state; sleep overrides everything else
    always_comb begin
        if (sleep_sync) begin
            next_state = pbs_pkg::SR_SLEEP;
        end else begin
            unique case (state)
                pbs_pkg::SR_SLEEP, pbs_pkg::SR_DESEL: begin
                    next_state = start ? pbs_pkg::SR_ACTIVE : pbs_pkg::SR_DESEL;
                end
                pbs_pkg::SR_ACTIVE: begin
                    next_state = desel ? pbs_pkg::SR_DESEL : pbs_pkg::SR_ACTIVE;
                end
                default: next_state = pbs_pkg::SR_DESEL;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= pbs_pkg::SR_DESEL;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Burst counter and captured start address
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            base_addr <= '0;
            beat <= pbs_pkg::BEAT_FIRST;
            linear <= 1'b0;
        end else if (!sleep_sync) begin
            if (start) begin
                base_addr <= bus.addr;
                linear <= bus.burst_linear;
            end
            if (cyc_live) begin
                beat <= next_beat;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read pipeline; deselect and sleep empty it at once
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_addr <= '0;
            rd_stage1 <= 1'b0;
            rd_stage2 <= 1'b0;
            wr_busy <= 1'b0;
        end else if (sleep_sync) begin
            rd_stage1 <= 1'b0;
            rd_stage2 <= 1'b0;
            wr_busy <= 1'b0;
        end else begin
            rd_addr <= use_addr;
            rd_stage1 <= cyc_live && !wr_cyc;
            // Stage one is empty after a deselect, so the first cycle never drives
            rd_stage2 <= rd_stage1 && !desel;
            wr_busy <= wr_cyc;
        end
    end

    // Output register; loads every edge so a suspend cycle repeats the word
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dout <= '0;
        end else begin
            dout <= mem[rd_addr];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Array write; no reset so contents survive reset and sleep alike
    always_ff @(posedge sys_clk) begin
        if (nrst && wr_cyc && !sleep_sync) begin
            for (int i = 0; i < pbs_pkg::LANES; i++) begin
                if (next_mask[i]) begin
                    mem[use_addr][i*pbs_pkg::BYTE_W +: pbs_pkg::BYTE_W] <=
                        bus.data_io[i*pbs_pkg::BYTE_W +: pbs_pkg::BYTE_W];
                    mem[use_addr][pbs_pkg::DATA_W + i] <= bus.parity_io[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive; output enable and sleep act without the clock
    // Relies on the partner raising output enable before it drives write data
    always_comb begin
        bus.sram_io_oe_n = !(rd_stage2 && !wr_busy
                             && !bus.output_enable_n && state == pbs_pkg::SR_ACTIVE
                             && !bus.sleep_request && !sleep_sync);
    end

    assign bus.sram_data_o = dout[pbs_pkg::DATA_W-1:0];
    assign bus.sram_parity_o = dout[pbs_pkg::WORD_W-1:pbs_pkg::DATA_W];

    assign sleeping = sleep_sync;
    assign selected = state == pbs_pkg::SR_ACTIVE;
    assign write_busy = wr_busy;

endmodule

// >>> core/pbs_pkg.sv
package pbs_pkg;

    localparam int ADDR_W_DEF = 17;
    localparam int DATA_W = 32;
    localparam int PAR_W = 4;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 36;

    // Clock and sleep timing; clock period in ns, sleep times in clock periods
    localparam int CLK_PERIOD_NS = 40;
    localparam int SLEEP_ENTRY_TIME_TCYC = 2;
    localparam int SLEEP_RECOVERY_TIME_TCYC = 2;
    localparam int SLEEP_RECOVERY_CYCLES = SLEEP_RECOVERY_TIME_TCYC * CLK_PERIOD_NS / CLK_PERIOD_NS;

    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_STEP = 2'h1;
    localparam logic [1:0] BEAT_LAST = 2'h3;
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [3:0] MASK_ALL = 4'hF;
    localparam logic [3:0] SELECT_NONE_N = 4'hF;
    localparam logic [2:0] READ_PIPE_EMPTY = 3'h0;

    typedef enum logic [2:0] {
        SR_DESEL = 3'b001,
        SR_ACTIVE = 3'b010,
        SR_SLEEP = 3'b100
    } pbs_sram_state_t;

    typedef enum logic [5:0] {
        CT_IDLE = 6'b000001,
        CT_READ = 6'b000010,
        CT_WRITE = 6'b000100,
        CT_DESEL = 6'b001000,
        CT_SLEEP = 6'b010000,
        CT_WAKE = 6'b100000
    } pbs_ctrl_state_t;

    // Low address bits of a beat: xor for interleaved, wrapping sum for linear
    function automatic logic [1:0] burst_lo(input logic [1:0] first, input logic [1:0] beat,
                                            input logic linear);
        burst_lo = linear ? 2'(first + beat) : (first ^ beat);
    endfunction

    // Lanes written from global write, byte-write enable and byte selects
    function automatic logic [3:0] lane_mask(input logic gw_n, input logic bwe_n,
                                             input logic [3:0] sel_n);
        if (!gw_n) begin
            lane_mask = MASK_ALL;
        end else if (!bwe_n) begin
            lane_mask = ~sel_n;
        end else begin
            lane_mask = MASK_NONE;
        end
    endfunction

endpackage

// >>> core/pbs_if.sv
`timescale 1ns/10ps
interface pbs_if #(
    parameter int ADDR_W = pbs_pkg::ADDR_W_DEF
);
    logic [ADDR_W-1:0] addr;
    logic chip_select_one_n;
    logic chip_select_two;
    logic chip_select_three_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic [3:0] byte_select_n;
    logic output_enable_n;
    logic sleep_request;
    logic burst_linear;
    logic [31:0] ctrl_data_o;
    logic [3:0] ctrl_parity_o;
    logic ctrl_io_oe_n;
    logic [31:0] sram_data_o;
    logic [3:0] sram_parity_o;
    logic sram_io_oe_n;
    logic [31:0] data_io;
    logic [3:0] parity_io;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared data lines; undriven lines read as zero
    assign data_io = !sram_io_oe_n ? sram_data_o : (!ctrl_io_oe_n ? ctrl_data_o : '0);
    assign parity_io = !sram_io_oe_n ? sram_parity_o : (!ctrl_io_oe_n ? ctrl_parity_o : '0);

    modport sram (
        input addr, chip_select_one_n, chip_select_two, chip_select_three_n,
        input processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
        input global_write_n, byte_write_enable_n, byte_select_n,
        input output_enable_n, sleep_request, burst_linear,
        input data_io, parity_io,
        output sram_data_o, sram_parity_o, sram_io_oe_n
    );

    modport ctrl (
        output addr, chip_select_one_n, chip_select_two, chip_select_three_n,
        output processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
        output global_write_n, byte_write_enable_n, byte_select_n,
        output output_enable_n, sleep_request, burst_linear,
        output ctrl_data_o, ctrl_parity_o, ctrl_io_oe_n,
        input data_io, parity_io
    );
endinterface

// >>> core/pbs_ctrl.sv
`timescale 1ns/10ps
module pbs_ctrl #(
    parameter int ADDR_W = pbs_pkg::ADDR_W_DEF
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_burst,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [3:0] cmd_byte_en,
    input wire logic [pbs_pkg::WORD_W-1:0] wr_data,
    output logic wr_take,
    output logic [pbs_pkg::WORD_W-1:0] rd_data,
    output logic rd_valid,
    input wire logic burst_linear,
    input wire logic sleep_req,
    output logic sleep_active,
    pbs_if.ctrl bus
);

    if (ADDR_W < 2 || ADDR_W > 24) begin : g_chk
        $error("pbs_ctrl: ADDR_W out of range");
    end

    pbs_pkg::pbs_ctrl_state_t state;
    logic [1:0] beat;
    logic [1:0] last;
    logic [3:0] byte_en;
    logic [2:0] rd_pipe;
    logic [2:0] next_rd_pipe;
    logic [1:0] wake_cnt;
    logic take;
    logic rd_issue;

    ////////////////////////////////////////////////////////////////////////////////
    // Commands wait for the pipe to drain so output enable is high before a write
    always_comb begin
        cmd_ready = (state == pbs_pkg::CT_IDLE) && (rd_pipe == pbs_pkg::READ_PIPE_EMPTY)
                    && !sleep_req;
        take = cmd_valid && cmd_ready;
        wr_take = (take && cmd_write) || (state == pbs_pkg::CT_WRITE);
        rd_issue = (take && !cmd_write) || (state == pbs_pkg::CT_READ);
        next_rd_pipe = {rd_pipe[1:0], rd_issue};
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_pipe <= pbs_pkg::READ_PIPE_EMPTY;
            bus.output_enable_n <= 1'b1;
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_pipe <= next_rd_pipe;
            bus.output_enable_n <= next_rd_pipe == pbs_pkg::READ_PIPE_EMPTY;
            rd_valid <= rd_pipe[2];
            if (rd_pipe[2]) begin
                rd_data <= {bus.parity_io, bus.data_io};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sequencing; strobes and write inputs fall back each edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= pbs_pkg::CT_IDLE;
            beat <= pbs_pkg::BEAT_FIRST;
            last <= pbs_pkg::BEAT_FIRST;
            byte_en <= pbs_pkg::MASK_NONE;
            wake_cnt <= 2'h0;
            bus.addr <= '0;
            bus.chip_select_one_n <= 1'b0;
            bus.chip_select_two <= 1'b1;
            bus.chip_select_three_n <= 1'b0;
            bus.processor_addr_strobe_n <= 1'b1;
            bus.controller_addr_strobe_n <= 1'b1;
            bus.burst_advance_n <= 1'b1;
            bus.global_write_n <= 1'b1;
            bus.byte_write_enable_n <= 1'b1;
            bus.byte_select_n <= pbs_pkg::SELECT_NONE_N;
            bus.ctrl_data_o <= '0;
            bus.ctrl_parity_o <= '0;
            bus.ctrl_io_oe_n <= 1'b1;
            bus.sleep_request <= 1'b0;
            bus.burst_linear <= 1'b0;
        end else begin
            bus.burst_linear <= burst_linear;
            bus.processor_addr_strobe_n <= 1'b1;
            bus.controller_addr_strobe_n <= 1'b1;
            bus.burst_advance_n <= 1'b1;
            bus.global_write_n <= 1'b1;
            bus.byte_write_enable_n <= 1'b1;
            bus.byte_select_n <= pbs_pkg::SELECT_NONE_N;
            bus.ctrl_io_oe_n <= 1'b1;
            if (wr_take) begin
                bus.ctrl_data_o <= wr_data[31:0];
                bus.ctrl_parity_o <= wr_data[35:32];
                bus.ctrl_io_oe_n <= 1'b0;
                bus.global_write_n <= !(take ? &cmd_byte_en : &byte_en);
                bus.byte_write_enable_n <= take ? &cmd_byte_en : &byte_en;
                bus.byte_select_n <= take ? ~cmd_byte_en : ~byte_en;
            end
            unique case (state)
                pbs_pkg::CT_IDLE: begin
                    if (sleep_req && rd_pipe == pbs_pkg::READ_PIPE_EMPTY) begin
                        bus.chip_select_one_n <= 1'b1;
                        bus.chip_select_two <= 1'b0;
                        bus.chip_select_three_n <= 1'b1;
                        bus.controller_addr_strobe_n <= 1'b0;
                        state <= pbs_pkg::CT_DESEL;
                    end else if (take) begin
                        bus.addr <= cmd_addr;
                        byte_en <= cmd_byte_en;
                        beat <= pbs_pkg::BEAT_FIRST;
                        last <= cmd_burst ? pbs_pkg::BEAT_LAST : pbs_pkg::BEAT_FIRST;
                        if (cmd_write) begin
                            bus.controller_addr_strobe_n <= 1'b0;
                        end else begin
                            bus.processor_addr_strobe_n <= 1'b0;
                        end
                        if (cmd_burst) begin
                            state <= cmd_write ? pbs_pkg::CT_WRITE : pbs_pkg::CT_READ;
                        end
                    end
                end
                pbs_pkg::CT_READ, pbs_pkg::CT_WRITE: begin
                    bus.burst_advance_n <= 1'b0;
                    beat <= 2'(beat + pbs_pkg::BEAT_STEP);
                    if (2'(beat + pbs_pkg::BEAT_STEP) == last) begin
                        state <= pbs_pkg::CT_IDLE;
                    end
                end
                pbs_pkg::CT_DESEL: begin
                    bus.sleep_request <= 1'b1;
                    state <= pbs_pkg::CT_SLEEP;
                end
                pbs_pkg::CT_SLEEP: begin
                    if (!sleep_req) begin
                        bus.sleep_request <= 1'b0;
                        wake_cnt <= 2'h0;
                        state <= pbs_pkg::CT_WAKE;
                    end
                end
                pbs_pkg::CT_WAKE: begin
                    wake_cnt <= 2'(wake_cnt + 2'h1);
                    if (int'(wake_cnt) + 1 == pbs_pkg::SLEEP_RECOVERY_CYCLES) begin
                        bus.chip_select_one_n <= 1'b0;
                        bus.chip_select_two <= 1'b1;
                        bus.chip_select_three_n <= 1'b0;
                        state <= pbs_pkg::CT_IDLE;
                    end
                end
                default: state <= pbs_pkg::CT_IDLE;
            endcase
        end
    end

    // Selects come up active after reset so the first command needs no extra cycle
    assign sleep_active = bus.sleep_request;

endmodule

// >>> testbench/pbs_properties.sv
`timescale 1ns/10ps
module pbs_properties (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic chip_select_one_n,
    input wire logic chip_select_two,
    input wire logic chip_select_three_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic ctrl_io_oe_n,
    input wire logic sram_io_oe_n
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    logic all_sel;
    logic start;
    logic desel;
    logic quiet;
    logic was_desel;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle decode as seen on the pins
    assign all_sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
    assign start = all_sel && (!processor_addr_strobe_n || !controller_addr_strobe_n);
    assign desel = !all_sel && (!controller_addr_strobe_n
                                || (!processor_addr_strobe_n && !chip_select_one_n));
    assign quiet = chip_select_one_n && !chip_select_two && chip_select_three_n
                   && processor_addr_strobe_n && controller_addr_strobe_n;

    // Sleep counts as deselected: the first access after wake is masked too
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            was_desel <= 1'b1;
        end else if (sleep_request || desel) begin
            was_desel <= 1'b1;
        end else if (start) begin
            was_desel <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_sleep_float: assert property (sleep_request |-> sram_io_oe_n)
        else $error("memory drives pins during sleep");
    a_oe_gate: assert property (!sram_io_oe_n |-> !output_enable_n)
        else $error("memory drives pins with output enable off");
    a_write_float: assert property (!ctrl_io_oe_n |-> sram_io_oe_n)
        else $error("memory drives pins during a write");
    a_write_oe_off: assert property (!ctrl_io_oe_n |-> output_enable_n)
        else $error("output enable active while controller drives");
    a_begin_float: assert property (start && was_desel |=> sram_io_oe_n)
        else $error("first cycle after deselect not floating");
    a_desel_float: assert property (desel |=> sram_io_oe_n)
        else $error("pins driven after deselect");
    a_wake_quiet: assert property ($fell(sleep_request) |-> quiet ##1 quiet)
        else $error("selects or strobes active during recovery");
    a_sleep_desel: assert property ($rose(sleep_request) |-> !all_sel)
        else $error("sleep requested while selected");

    c_begin: cover property (start && was_desel);
    c_read_out: cover property (!sram_io_oe_n);
    c_write: cover property (!ctrl_io_oe_n);
    c_wake: cover property ($fell(sleep_request));
endmodule

// >>> testbench/pipelined_burst_sram_control_test.sv
`timescale 1ns/10ps
module pipelined_burst_sram_control_test;
    localparam int AW = 6;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic cmd_burst = 1'b0;
    logic [AW-1:0] cmd_addr = '0;
    logic [3:0] cmd_byte_en = 4'h0;
    logic [pbs_pkg::WORD_W-1:0] wr_data = '0;
    logic burst_linear = 1'b0;
    logic sleep_req = 1'b0;
    logic cmd_ready, wr_take, rd_valid, sleep_active, sleeping, selected, write_busy;
    logic [pbs_pkg::WORD_W-1:0] rd_data;
    logic [pbs_pkg::WORD_W-1:0] mem [64];
    logic [pbs_pkg::WORD_W-1:0] beats [4];
    logic [pbs_pkg::WORD_W-1:0] rdq [$];
    int num_errors = 0;
    int check_count = 0;

    always #20 sys_clk = ~sys_clk;

    pbs_if #(.ADDR_W(AW)) bus_if ();
    pbs_ctrl #(.ADDR_W(AW)) i_pbs_ctrl (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_burst(cmd_burst),
        .cmd_addr(cmd_addr), .cmd_byte_en(cmd_byte_en), .wr_data(wr_data), .wr_take(wr_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .burst_linear(burst_linear),
        .sleep_req(sleep_req), .sleep_active(sleep_active), .bus(bus_if));
    pbs_sram #(.ADDR_W(AW)) i_pbs_sram (.sys_clk(sys_clk), .nrst(nrst), .sleeping(sleeping),
        .selected(selected), .write_busy(write_busy), .bus(bus_if));
    pbs_properties i_pbs_properties (.sys_clk(sys_clk), .nrst(nrst),
        .chip_select_one_n(bus_if.chip_select_one_n), .chip_select_two(bus_if.chip_select_two),
        .chip_select_three_n(bus_if.chip_select_three_n),
        .processor_addr_strobe_n(bus_if.processor_addr_strobe_n),
        .controller_addr_strobe_n(bus_if.controller_addr_strobe_n),
        .output_enable_n(bus_if.output_enable_n), .sleep_request(bus_if.sleep_request),
        .ctrl_io_oe_n(bus_if.ctrl_io_oe_n), .sram_io_oe_n(bus_if.sram_io_oe_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Sampled mid-cycle so the register update has landed
    always @(negedge sys_clk) begin
        if (rd_valid === 1'b1) begin
            rdq.push_back(rd_data);
        end
    end

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0] a, input int k,
                                                input logic lin);
        logic [1:0] kk;
        kk = 2'(k);
        beat_addr = {a[AW-1:2], lin ? 2'(a[1:0] + kk) : (a[1:0] ^ kk)};
    endfunction

    // Entered right after a rising edge; mode set a cycle ahead of the start
    task automatic do_cmd(input logic wr, input logic bu, input logic [AW-1:0] a,
                          input logic [3:0] be, input logic lin);
        int n;
        int t;
        logic acc;
        logic rdy;
        logic tk;
        n = 0;
        acc = 1'b0;
        burst_linear <= lin;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_burst <= bu;
        cmd_addr <= a;
        cmd_byte_en <= be;
        wr_data <= beats[0];
        for (t = 0; t < 40 && !(acc && (!wr || n == (bu ? 4 : 1))); t++) begin
            @(negedge sys_clk);
            rdy = cmd_ready;
            tk = wr_take;
            @(posedge sys_clk);
            if (rdy === 1'b1 && !acc) begin
                acc = 1'b1;
                cmd_valid <= 1'b0;
            end
            if (tk === 1'b1) begin
                n++;
                wr_data <= beats[n % 4];
            end
        end
        check("command finished", acc && (!wr || n == (bu ? 4 : 1)), 1'b1);
    endtask

    task automatic rd_check(input logic [AW-1:0] a, input logic bu, input logic lin);
        int t;
        int k;
        rdq.delete();
        do_cmd(1'b0, bu, a, 4'h0, lin);
        for (t = 0; t < 40 && rdq.size() < (bu ? 4 : 1); t++) @(negedge sys_clk);
        for (k = 0; k < (bu ? 4 : 1); k++) begin
            check("read word", rdq.size() > k ? rdq[k] : 'x, mem[beat_addr(a, k, lin)]);
        end
        @(posedge sys_clk);
    endtask

    task automatic sleep_cycle();
        int c;
        sleep_req <= 1'b1;
        for (c = 0; c < 20 && sleep_active !== 1'b1; c++) @(negedge sys_clk);
        for (c = 0; c < 20 && sleeping !== 1'b1; c++) @(negedge sys_clk);
        check("sleep entry", c <= pbs_pkg::SLEEP_ENTRY_TIME_TCYC, 1'b1);
        check("pins in sleep", bus_if.sram_io_oe_n, 1'b1);
        check("selected in sleep", selected, 1'b0);
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        for (c = 0; c < 20 && sleep_active !== 1'b0; c++) @(negedge sys_clk);
        for (c = 0; c < 20 && sleeping !== 1'b0; c++) @(negedge sys_clk);
        check("sleep exit", c == pbs_pkg::SLEEP_RECOVERY_CYCLES, 1'b1);
        @(posedge sys_clk);
    endtask

    initial begin
        repeat (10000) @(posedge sys_clk);
        num_errors++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        int a;
        int k;
        int s;
        logic lin;
        s = $urandom(73613);
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        // Sleep straight out of reset, before any access
        sleep_cycle();
        $display("test wake done");
        for (a = 0; a < 64; a += 4) begin
            lin = 1'($urandom());
            s = $urandom_range(3);
            for (k = 0; k < 4; k++) begin
                beats[k] = 36'({$urandom(), $urandom()});
                mem[beat_addr(AW'(a + s), k, lin)] = beats[k];
            end
            do_cmd(1'b1, 1'b1, AW'(a + s), 4'hF, lin);
        end
        $display("test burst fill done");
        for (k = 1; k < 16; k++) begin
            a = $urandom_range(63);
            beats[0] = 36'({$urandom(), $urandom()});
            for (s = 0; s < 4; s++) begin
                if (k[s]) begin
                    mem[a][8*s +: 8] = beats[0][8*s +: 8];
                    mem[a][32+s] = beats[0][32+s];
                end
            end
            do_cmd(1'b1, 1'b0, AW'(a), 4'(k), 1'b0);
            // Controller-strobe start writes on its own edge
            repeat (2) @(negedge sys_clk);
            check("write busy", write_busy, 1'b1);
            check("selected", selected, 1'b1);
            @(posedge sys_clk);
            rd_check(AW'(a), 1'b0, 1'b0);
        end
        $display("test byte lanes done");
        for (a = 0; a < 64; a += 4) begin
            rd_check(AW'(a + $urandom_range(3)), 1'b1, 1'($urandom()));
        end
        $display("test burst read done");
        sleep_cycle();
        for (k = 0; k < 8; k++) begin
            rd_check(AW'($urandom_range(63)), 1'b0, 1'b0);
        end
        $display("test retention done");
        print_verdict();
    end
endmodule
